// ### design/sfsw_pkg.sv
// Purpose: Shared constants, state type and helpers of the serial flash command block.
// Assumes: 125 MHz system clock; serial link sampled as plain inputs.
// Notes:   Opcodes, status bit positions and phase lengths are defined here; sfsw_status and the assertions also fix busy at bit 0 and WEL at bit 1.
package sfsw_pkg;
  // Opcodes
  localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
  localparam logic [7:0] OP_READ         = 8'h03;
  localparam logic [7:0] OP_FAST_READ    = 8'h0b;
  localparam logic [7:0] OP_DUAL_OUT     = 8'h3b;
  localparam logic [7:0] OP_DUAL_IO      = 8'hbb;
  localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
  localparam logic [7:0] OP_STAT_RD_LO   = 8'h05;
  localparam logic [7:0] OP_STAT_RD_HI   = 8'h35;
  localparam logic [7:0] OP_NONE         = 8'h00;

  // Phase lengths as last clock index; status write lengths as bit counts
  localparam logic [4:0] OPC_LAST        = 5'h07;
  localparam logic [4:0] ADDR_SGL_LAST   = 5'h17;
  localparam logic [4:0] ADDR_DUAL_LAST  = 5'h0b;
  localparam logic [4:0] MODE_LAST       = 5'h03;
  localparam logic [4:0] DUMMY_LAST      = 5'h07;
  localparam logic [4:0] DUMMY_M_LAST    = 5'h03;
  localparam logic [4:0] WR_SHORT_BITS   = 5'h08;
  localparam logic [4:0] WR_LONG_BITS    = 5'h10;
  localparam logic [4:0] CNT_SAT         = 5'h1f;
  localparam logic [2:0] SGL_BYTE_LAST   = 3'h7;
  localparam logic [2:0] DUAL_BYTE_LAST  = 3'h3;
  localparam logic [1:0] MODE_KEEP       = 2'h2;

  // Status bit positions, masks and reset value
  localparam int          ST_BUSY        = 0;
  localparam int          ST_WEL         = 1;
  localparam int          ST_SRP_LO      = 7;
  localparam int          ST_SRP_HI      = 8;
  localparam logic [15:0] ST_WRITE_MASK  = 16'h7bfc;
  localparam logic [15:0] ST_OTP_MASK    = 16'h3800;
  localparam logic [15:0] ST_SHORT_CLEAR = 16'h4300;
  localparam logic [15:0] ST_RESET       = 16'h0000;

  // Self-timed status write duration
  localparam int unsigned CLK_PERIOD_NS        = 8;
  localparam int unsigned STATUS_WRITE_CYCLE_NS = 5000000;
  localparam int unsigned STATUS_WRITE_CYCLES  = STATUS_WRITE_CYCLE_NS / CLK_PERIOD_NS;

  // Gray coded along opcode, address, mode, dummy, data
  typedef enum logic [2:0] {
    SFSW_OPC   = 3'h0,
    SFSW_ADDR  = 3'h1,
    SFSW_MODE  = 3'h3,
    SFSW_DUMMY = 3'h2,
    SFSW_DATA  = 3'h6,
    SFSW_SRD   = 3'h7,
    SFSW_WRD   = 3'h5,
    SFSW_IGN   = 3'h4
  } sfsw_state_e;

  // Hardware lock from protect-mode bits and protect pin
  function automatic logic sfsw_locked(input logic srp_hi, input logic srp_lo,
                                       input logic wp_n);
    return srp_hi | (srp_lo & ~wp_n);
  endfunction : sfsw_locked
endpackage : sfsw_pkg

// ### design/sfsw_sync.sv
// Purpose: Two-stage synchroniser for pin inputs.
// Assumes: Inputs are asynchronous levels.
// Notes:   First stage is read only by the second.
`timescale 1ns/1ps
module sfsw_sync #(
  parameter int W = 1
) (
  input  wire logic         sys_clk,
  input  wire logic         rstn,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  logic [W-1:0] meta_r;

  // Two flops in series
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      meta_r <= '0;
      dout   <= '0;
    end else begin
      meta_r <= din;
      dout   <= meta_r;
    end
  end
endmodule : sfsw_sync

// ### design/sfsw_status.sv
// Purpose: Status register, write-enable latch and self-timed write cycle.
// Assumes: Commit and latch pulses come from the command decoder.
// Notes:   New status is applied at cycle start; busy covers the timed cycle.
`timescale 1ns/1ps
module sfsw_status #(
  parameter int unsigned CYCLES = sfsw_pkg::STATUS_WRITE_CYCLES
) (
  input  wire logic        sys_clk,
  input  wire logic        rstn,
  input  wire logic        wr_go,
  input  wire logic        wr_long,
  input  wire logic [15:0] wr_data,
  input  wire logic        write_enable_command,
  input  wire logic        ext_busy,
  output logic      [15:0] status
);
  logic [15:2] bits_r;
  logic        wel_r;
  logic        busy_r;
  logic [31:0] tmr_r;
  logic [15:0] cur;
  logic [15:0] din;
  logic [15:0] nxt;
  logic        done;

  assign cur  = {bits_r, wel_r, busy_r};
  assign done = (tmr_r == 32'h1);

  // Short write keeps the upper byte but clears bits 14, 9 and 8; first byte lands low
  always_comb begin
    din = wr_long ? {wr_data[7:0], wr_data[15:8]} : {cur[15:8], wr_data[7:0]};
    nxt = (cur & ~sfsw_pkg::ST_WRITE_MASK) | (din & sfsw_pkg::ST_WRITE_MASK);
    nxt = nxt | (cur & sfsw_pkg::ST_OTP_MASK);
    if (!wr_long) begin
      nxt = nxt & ~sfsw_pkg::ST_SHORT_CLEAR;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      bits_r <= sfsw_pkg::ST_RESET[15:2];
    end else if (wr_go) begin
      bits_r <= nxt[15:2];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      tmr_r <= 32'h0;
    end else if (wr_go) begin
      tmr_r <= 32'(CYCLES);
    end else if (tmr_r != 32'h0) begin
      tmr_r <= tmr_r - 32'h1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      busy_r <= 1'b0;
    end else begin
      busy_r <= wr_go | (tmr_r > 32'h1) | ext_busy;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      wel_r <= 1'b0;
    end else if (write_enable_command) begin
      wel_r <= 1'b1;
    end else if (done) begin
      wel_r <= 1'b0;
    end
  end

  assign status = cur;
endmodule : sfsw_status

// ### design/sfsw_top.sv
// Purpose: Command handling of a serial NOR flash: status write and
//          single, fast, dual-output and dual-I/O reads.
// Assumes: Serial clock, chip select and data pins are asynchronous and are
//          sampled by sys_clk; serial clock is far slower than sys_clk.
// Notes:   Array is outside; mem_rdata answers mem_addr combinationally.
`timescale 1ns/1ps
module sfsw_top #(
  parameter int unsigned SW_CYCLES = sfsw_pkg::STATUS_WRITE_CYCLES
) (
  input  wire logic        sys_clk,
  input  wire logic        rstn,
  input  wire logic        cs_n,
  input  wire logic        sclk,
  input  wire logic        io0_in,
  output logic             io0_out,
  output logic             io0_oe_n,
  input  wire logic        io1_in,
  output logic             io1_out,
  output logic             io1_oe_n,
  input  wire logic        wp_n,
  input  wire logic        ext_busy,
  output logic      [23:0] mem_addr,
  input  wire logic [7:0]  mem_rdata,
  output logic      [15:0] status_reg,
  output logic             cont_mode
);
  logic [4:0]              pin_s;
  logic                    cs_s;
  logic                    sclk_s;
  logic                    io0_s;
  logic                    io1_s;
  logic                    wp_s;
  logic                    sclk_d_r;
  logic                    cs_d_r;
  logic                    sck_rise;
  logic                    sck_fall;
  logic                    cs_rise;
  logic                    cs_fall;
  sfsw_pkg::sfsw_state_e   state_r;
  logic [4:0]              cnt_r;
  logic [7:0]              cmd_r;
  logic [23:0]             in_sh_r;
  logic [23:0]             sh_next;
  logic                    dual_in;
  logic                    dual_out;
  logic                    busy;
  logic                    locked;
  logic [4:0]              addr_last;
  logic [4:0]              dummy_last;
  logic [7:0]              op;
  logic [23:0]             addr_r;
  logic [7:0]              out_sh_r;
  logic [2:0]              ocnt_r;
  logic                    loaded_r;
  logic [7:0]              load_byte;
  logic                    wr_go_r;
  logic                    wr_long_r;
  logic [15:0]             wr_data_r;
  logic                    write_enable_command_r;
  logic                    cont_r;
  logic [15:0]             status;

  // Pin synchronisers; select and protect inverted so reset equals idle
  sfsw_sync #(
    .W (5)
  ) u_sync (
    .sys_clk (sys_clk),
    .rstn    (rstn),
    .din     ({~cs_n, sclk, io1_in, io0_in, ~wp_n}),
    .dout    (pin_s)
  );

  assign cs_s   = ~pin_s[4];
  assign sclk_s = pin_s[3];
  assign io1_s  = pin_s[2];
  assign io0_s  = pin_s[1];
  assign wp_s   = ~pin_s[0];

  // Status register and timed cycle
  sfsw_status #(
    .CYCLES (SW_CYCLES)
  ) u_status (
    .sys_clk  (sys_clk),
    .rstn     (rstn),
    .wr_go    (wr_go_r),
    .wr_long  (wr_long_r),
    .wr_data  (wr_data_r),
    .write_enable_command     (write_enable_command_r),
    .ext_busy (ext_busy),
    .status   (status)
  );

  // Edge history of clock and select
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      sclk_d_r <= 1'b0;
      cs_d_r   <= 1'b1;
    end else begin
      sclk_d_r <= sclk_s;
      cs_d_r   <= cs_s;
    end
  end

  assign sck_rise = sclk_s & ~sclk_d_r & ~cs_s;
  assign sck_fall = ~sclk_s & sclk_d_r & ~cs_s;
  assign cs_rise  = cs_s & ~cs_d_r;
  assign cs_fall  = ~cs_s & cs_d_r;

  assign busy   = status[sfsw_pkg::ST_BUSY];
  assign locked = sfsw_pkg::sfsw_locked(status[sfsw_pkg::ST_SRP_HI],
                                        status[sfsw_pkg::ST_SRP_LO], wp_s);

  assign dual_in  = (cmd_r == sfsw_pkg::OP_DUAL_IO) && (state_r != sfsw_pkg::SFSW_OPC);
  assign dual_out = (cmd_r == sfsw_pkg::OP_DUAL_IO) || (cmd_r == sfsw_pkg::OP_DUAL_OUT);
  assign sh_next  = dual_in ? {in_sh_r[21:0], io1_s, io0_s} : {in_sh_r[22:0], io0_s};
  assign op       = sh_next[7:0];
  assign addr_last  = dual_in ? sfsw_pkg::ADDR_DUAL_LAST : sfsw_pkg::ADDR_SGL_LAST;
  assign dummy_last = (cmd_r == sfsw_pkg::OP_DUAL_IO) ? sfsw_pkg::DUMMY_M_LAST
                                                      : sfsw_pkg::DUMMY_LAST;

  // Input shifter
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      in_sh_r <= 24'h0;
    end else if (sck_rise) begin
      in_sh_r <= sh_next;
    end
  end

  // Command phase sequencer
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      state_r <= sfsw_pkg::SFSW_OPC;
      cnt_r   <= 5'h0;
      cmd_r   <= sfsw_pkg::OP_NONE;
    end else if (cs_fall) begin
      cnt_r <= 5'h0;
      if (cont_r) begin
        cmd_r   <= sfsw_pkg::OP_DUAL_IO;
        state_r <= busy ? sfsw_pkg::SFSW_IGN : sfsw_pkg::SFSW_ADDR;
      end else begin
        cmd_r   <= sfsw_pkg::OP_NONE;
        state_r <= sfsw_pkg::SFSW_OPC;
      end
    end else if (cs_s) begin
      state_r <= sfsw_pkg::SFSW_OPC;
      cnt_r   <= 5'h0;
    end else if (sck_rise) begin
      case (state_r)
        sfsw_pkg::SFSW_OPC: begin
          if (cnt_r == sfsw_pkg::OPC_LAST) begin
            cmd_r <= op;
            cnt_r <= 5'h0;
            case (op)
              sfsw_pkg::OP_READ: begin
                state_r <= busy ? sfsw_pkg::SFSW_IGN : sfsw_pkg::SFSW_ADDR;
              end
              sfsw_pkg::OP_FAST_READ, sfsw_pkg::OP_DUAL_OUT, sfsw_pkg::OP_DUAL_IO: begin
                state_r <= busy ? sfsw_pkg::SFSW_IGN : sfsw_pkg::SFSW_ADDR;
              end
              sfsw_pkg::OP_STATUS_WRITE: begin
                state_r <= busy ? sfsw_pkg::SFSW_IGN : sfsw_pkg::SFSW_WRD;
              end
              sfsw_pkg::OP_STAT_RD_LO, sfsw_pkg::OP_STAT_RD_HI: begin
                state_r <= sfsw_pkg::SFSW_SRD;
              end
              default: begin
                state_r <= sfsw_pkg::SFSW_IGN;
              end
            endcase
          end else begin
            cnt_r <= cnt_r + 5'h1;
          end
        end
        sfsw_pkg::SFSW_ADDR: begin
          if (cnt_r == addr_last) begin
            cnt_r <= 5'h0;
            if (cmd_r == sfsw_pkg::OP_DUAL_IO) begin
              state_r <= sfsw_pkg::SFSW_MODE;
            end else if (cmd_r == sfsw_pkg::OP_READ) begin
              state_r <= sfsw_pkg::SFSW_DATA;
            end else begin
              state_r <= sfsw_pkg::SFSW_DUMMY;
            end
          end else begin
            cnt_r <= cnt_r + 5'h1;
          end
        end
        sfsw_pkg::SFSW_MODE: begin
          if (cnt_r == sfsw_pkg::MODE_LAST) begin
            cnt_r   <= 5'h0;
            state_r <= sfsw_pkg::SFSW_DUMMY;
          end else begin
            cnt_r <= cnt_r + 5'h1;
          end
        end
        sfsw_pkg::SFSW_DUMMY: begin
          if (cnt_r == dummy_last) begin
            cnt_r   <= 5'h0;
            state_r <= sfsw_pkg::SFSW_DATA;
          end else begin
            cnt_r <= cnt_r + 5'h1;
          end
        end
        sfsw_pkg::SFSW_WRD, sfsw_pkg::SFSW_IGN: begin
          if (cnt_r != sfsw_pkg::CNT_SAT) begin
            cnt_r <= cnt_r + 5'h1;
          end
        end
        default: begin
          cnt_r <= cnt_r;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      cont_r <= 1'b0;
    end else if (sck_rise && (state_r == sfsw_pkg::SFSW_MODE)
                 && (cnt_r == sfsw_pkg::MODE_LAST)) begin
      cont_r <= (op[5:4] == sfsw_pkg::MODE_KEEP);
    end
  end

  // Status data collected msb first
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      wr_data_r <= 16'h0;
    end else if (sck_rise && (state_r == sfsw_pkg::SFSW_WRD)) begin
      wr_data_r <= {wr_data_r[14:0], io0_s};
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      wr_go_r   <= 1'b0;
      wr_long_r <= 1'b0;
    end else begin
      wr_go_r   <= cs_rise && (state_r == sfsw_pkg::SFSW_WRD) && !busy && !locked
                   && status[sfsw_pkg::ST_WEL]
                   && ((cnt_r == sfsw_pkg::WR_SHORT_BITS)
                       || (cnt_r == sfsw_pkg::WR_LONG_BITS));
      wr_long_r <= (cnt_r == sfsw_pkg::WR_LONG_BITS);
    end
  end

  // Write-enable command executes at select rise
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      write_enable_command_r <= 1'b0;
    end else begin
      write_enable_command_r <= cs_rise && (state_r == sfsw_pkg::SFSW_IGN) && !busy
                && (cmd_r == sfsw_pkg::OP_WRITE_ENABLE) && (cnt_r == 5'h0);
    end
  end

  // Byte to send next
  always_comb begin
    if (state_r == sfsw_pkg::SFSW_SRD) begin
      load_byte = (cmd_r == sfsw_pkg::OP_STAT_RD_HI) ? status[15:8] : status[7:0];
    end else begin
      load_byte = mem_rdata;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      addr_r <= 24'h0;
    end else if (sck_rise && (state_r == sfsw_pkg::SFSW_ADDR) && (cnt_r == addr_last)) begin
      addr_r <= sh_next;
    end else if (sck_fall && (state_r == sfsw_pkg::SFSW_DATA) && (ocnt_r == 3'h0)) begin
      addr_r <= addr_r + 24'h1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      out_sh_r <= 8'h0;
      ocnt_r   <= 3'h0;
      loaded_r <= 1'b0;
      io0_out  <= 1'b0;
      io1_out  <= 1'b0;
    end else if (cs_s) begin
      ocnt_r   <= 3'h0;
      loaded_r <= 1'b0;
    end else if (sck_fall && ((state_r == sfsw_pkg::SFSW_DATA)
                              || (state_r == sfsw_pkg::SFSW_SRD))) begin
      loaded_r <= 1'b1;
      if (ocnt_r == 3'h0) begin
        if (dual_out && (state_r == sfsw_pkg::SFSW_DATA)) begin
          io1_out  <= load_byte[7];
          io0_out  <= load_byte[6];
          out_sh_r <= {load_byte[5:0], 2'h0};
          ocnt_r   <= sfsw_pkg::DUAL_BYTE_LAST;
        end else begin
          io1_out  <= load_byte[7];
          out_sh_r <= {load_byte[6:0], 1'b0};
          ocnt_r   <= sfsw_pkg::SGL_BYTE_LAST;
        end
      end else begin
        ocnt_r <= ocnt_r - 3'h1;
        if (dual_out && (state_r == sfsw_pkg::SFSW_DATA)) begin
          io1_out  <= out_sh_r[7];
          io0_out  <= out_sh_r[6];
          out_sh_r <= {out_sh_r[5:0], 2'h0};
        end else begin
          io1_out  <= out_sh_r[7];
          out_sh_r <= {out_sh_r[6:0], 1'b0};
        end
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      io1_oe_n <= 1'b1;
      io0_oe_n <= 1'b1;
    end else if (cs_s) begin
      io1_oe_n <= 1'b1;
      io0_oe_n <= 1'b1;
    end else if (sck_fall && ((state_r == sfsw_pkg::SFSW_DATA)
                              || (state_r == sfsw_pkg::SFSW_SRD))) begin
      io1_oe_n <= 1'b0;
      io0_oe_n <= !(dual_out && (state_r == sfsw_pkg::SFSW_DATA));
    end
  end

  // Registered views for the user side
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      status_reg <= sfsw_pkg::ST_RESET;
      cont_mode  <= 1'b0;
    end else begin
      status_reg <= status;
      cont_mode  <= cont_r;
    end
  end

  assign mem_addr = addr_r;
endmodule : sfsw_top

// ### verification/sfsw_top_assertions.sv
// Purpose: Port assertions of the serial flash command block.
// Assumes: ext_busy low unless other logic drives it.
// Notes:   Bound to every sfsw_top instance.
`timescale 1ns/1ps
module sfsw_top_assertions #(
  parameter int unsigned SW_CYCLES = 50
) (
  input wire logic        sys_clk,
  input wire logic        rstn,
  input wire logic        cs_n,
  input wire logic        sclk,
  input wire logic        io0_in,
  input wire logic        io0_out,
  input wire logic        io0_oe_n,
  input wire logic        io1_in,
  input wire logic        io1_out,
  input wire logic        io1_oe_n,
  input wire logic        wp_n,
  input wire logic        ext_busy,
  input wire logic [23:0] mem_addr,
  input wire logic [7:0]  mem_rdata,
  input wire logic [15:0] status_reg,
  input wire logic        cont_mode
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  logic [31:0] busy_len_r;
  // Length of the current busy stretch
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      busy_len_r <= 32'h0;
    end else if (status_reg[0]) begin
      busy_len_r <= busy_len_r + 32'h1;
    end else begin
      busy_len_r <= 32'h0;
    end
  end
  property p_busy_len; $fell(status_reg[0]) && !ext_busy |-> busy_len_r == 32'(SW_CYCLES);
  endproperty
  a_busy_len: assert property (p_busy_len) else $error("busy length wrong");
  // Pins released once select stays high
  property p_oe_idle; cs_n [*5] |-> io0_oe_n && io1_oe_n; endproperty
  a_oe_idle: assert property (p_oe_idle) else $error("pin driven outside frame");
  property p_dual_pair; !io0_oe_n |-> !io1_oe_n; endproperty
  a_dual_pair: assert property (p_dual_pair) else $error("io0 driven alone");
  property p_keep_fixed; $stable(status_reg[15]) && $stable(status_reg[10]); endproperty
  a_keep_fixed: assert property (p_keep_fixed) else $error("fixed status bit moved");
  property p_busy_hold; $rose(status_reg[0]) && !ext_busy |-> status_reg[0] [*8]; endproperty
  a_busy_hold: assert property (p_busy_hold) else $error("busy too short");
  property p_latch_clear; $fell(status_reg[0]) && !ext_busy |-> ##[0:1] !status_reg[1];
  endproperty
  a_latch_clear: assert property (p_latch_clear) else $error("latch kept");
  property p_latch_held; status_reg[0] && !ext_busy |-> status_reg[1]; endproperty
  a_latch_held: assert property (p_latch_held) else $error("write without latch");
  property p_update_busy; !$stable(status_reg[15:2]) |-> ##[0:1] status_reg[0]; endproperty
  a_update_busy: assert property (p_update_busy) else $error("status moved idle");
  property p_no_dual_busy; status_reg[0] |-> io0_oe_n; endproperty
  a_no_dual_busy: assert property (p_no_dual_busy) else $error("dual read while busy");
  property p_data_edge; !io1_oe_n && $changed(io1_out) |-> !sclk; endproperty
  a_data_edge: assert property (p_data_edge) else $error("data moved on high clock");
endmodule : sfsw_top_assertions

bind sfsw_top sfsw_top_assertions #(.SW_CYCLES(SW_CYCLES)) i_chk (
  .sys_clk(sys_clk), .rstn(rstn), .cs_n(cs_n), .sclk(sclk), .io0_in(io0_in),
  .io0_out(io0_out), .io0_oe_n(io0_oe_n), .io1_in(io1_in), .io1_out(io1_out),
  .io1_oe_n(io1_oe_n), .wp_n(wp_n), .ext_busy(ext_busy), .mem_addr(mem_addr),
  .mem_rdata(mem_rdata), .status_reg(status_reg), .cont_mode(cont_mode));

// ### verification/sfsw_host.sv
// Purpose: Host controller model driving the serial link.
// Assumes: Mode 0, 160 ns serial clock, moves on falling sys_clk.
// Notes:   Undriven lines toggle every serial clock.
`timescale 1ns/1ps
module sfsw_host (
  input  wire logic sys_clk,
  input  wire logic io0_out,
  input  wire logic io0_oe_n,
  input  wire logic io1_out,
  input  wire logic io1_oe_n,
  output logic      cs_n,
  output logic      sclk,
  output logic      io0_in,
  output logic      io1_in
);
  logic       h0 = 1'b0;
  logic       h1 = 1'b0;
  logic [1:0] q;
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
  end
  // Wire level, device wins when enabled
  assign io0_in = io0_oe_n ? h0 : io0_out;
  assign io1_in = io1_oe_n ? h1 : io1_out;
  task automatic cyc(input logic [1:0] d, input logic drv);
    @(negedge sys_clk);
    if (drv) {h1, h0} = d;
    else {h1, h0} = ~{h1, h0};
    repeat (9) @(negedge sys_clk);
    q = {io1_in, io0_in};
    sclk = 1'b1;
    repeat (10) @(negedge sys_clk);
    sclk = 1'b0;
  endtask : cyc
  task automatic byte1(input logic [7:0] v);
    for (int i = 7; i >= 0; i--) cyc({~h1, v[i]}, 1'b1);
  endtask : byte1
  task automatic byte2(input logic [7:0] v);
    for (int i = 3; i >= 0; i--) cyc(v[2*i +: 2], 1'b1);
  endtask : byte2
  task automatic rd1(output logic [7:0] r);
    for (int i = 0; i < 8; i++) begin
      cyc(2'b00, 1'b0);
      r = {r[6:0], q[1]};
    end
  endtask : rd1
  task automatic rd2(output logic [7:0] r);
    for (int i = 0; i < 4; i++) begin
      cyc(2'b00, 1'b0);
      r = {r[5:0], q};
    end
  endtask : rd2
  task automatic part();
    repeat (3) cyc(2'b00, 1'b0);
  endtask : part
  task automatic start();
    @(negedge sys_clk);
    cs_n = 1'b0;
    repeat (10) @(negedge sys_clk);
  endtask : start
  task automatic stop();
    repeat (10) @(negedge sys_clk);
    cs_n = 1'b1;
    repeat (20) @(negedge sys_clk);
  endtask : stop
endmodule : sfsw_host

// ### verification/test_serial_flash_status_write_and_reads.sv
// Purpose: Self-checking bench of the serial flash command block.
// Assumes: Array model answers mem_addr at once.
// Notes:   Short timed write cycle keeps the run brief.
`timescale 1ns/1ps
module test_serial_flash_status_write_and_reads;
  logic        sys_clk = 1'b0;
  logic        rstn = 1'b0;
  logic        wp_n = 1'b1;
  logic        cs_n, sclk, io0_in, io1_in, io0_out, io0_oe_n, io1_out, io1_oe_n, cont_mode;
  logic [23:0] mem_addr;
  logic [15:0] status_reg;
  logic [7:0]  mem_rdata;
  logic [7:0]  r;
  int          err_total = 0;
  int          samples_checked = 0;
  // Clock and array contents
  always #4 sys_clk = ~sys_clk;
  function automatic logic [7:0] memf(input logic [23:0] a);
    return a[7:0] ^ a[15:8] ^ a[23:16] ^ 8'h5a;
  endfunction : memf
  assign mem_rdata = memf(mem_addr);
  sfsw_top #(.SW_CYCLES(2000)) i_dut (
    .sys_clk(sys_clk), .rstn(rstn), .cs_n(cs_n), .sclk(sclk), .io0_in(io0_in),
    .io0_out(io0_out), .io0_oe_n(io0_oe_n), .io1_in(io1_in), .io1_out(io1_out),
    .io1_oe_n(io1_oe_n), .wp_n(wp_n), .ext_busy(1'b0), .mem_addr(mem_addr),
    .mem_rdata(mem_rdata), .status_reg(status_reg), .cont_mode(cont_mode));
  sfsw_host i_host (
    .sys_clk(sys_clk), .io0_out(io0_out), .io0_oe_n(io0_oe_n), .io1_out(io1_out),
    .io1_oe_n(io1_oe_n), .cs_n(cs_n), .sclk(sclk), .io0_in(io0_in), .io1_in(io1_in));
  // Compare and verdict
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic finish_test();
    if (err_total == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : finish_test
  task automatic wait_idle();
    int n;
    n = 0;
    while (status_reg[0] !== 1'b0 && n < 5000) begin
      @(negedge sys_clk);
      n++;
    end
    chk(24'(n < 5000), 24'h1);
  endtask : wait_idle
  // One read frame, optional opcode skip
  task automatic rd_test(input logic [7:0] op, input logic [23:0] a, input logic [7:0] m,
                         input int n, input logic skip);
    logic dual;
    dual = (op == sfsw_pkg::OP_DUAL_IO);
    i_host.start();
    if (!skip) i_host.byte1(op);
    for (int i = 2; i >= 0; i--) begin
      if (dual) i_host.byte2(a[8*i +: 8]);
      else i_host.byte1(a[8*i +: 8]);
    end
    if (dual) begin
      i_host.byte2(m);
      i_host.byte2(8'h00);
    end else if (op != sfsw_pkg::OP_READ) i_host.byte1(8'h00);
    for (int i = 0; i < n; i++) begin
      if (op == sfsw_pkg::OP_READ || op == sfsw_pkg::OP_FAST_READ) i_host.rd1(r);
      else i_host.rd2(r);
      chk(24'(r), 24'(memf(a + 24'(i))));
    end
    i_host.part();
    i_host.stop();
    chk(24'(io0_oe_n & io1_oe_n), 24'h1);
    chk(mem_addr, a + 24'(n) + 24'h1);
  endtask : rd_test
  task automatic write_enable_command();
    i_host.start();
    i_host.byte1(sfsw_pkg::OP_WRITE_ENABLE);
    i_host.stop();
  endtask : write_enable_command
  task automatic sw(input logic [7:0] b1, input logic [7:0] b2, input int nb);
    i_host.start();
    i_host.byte1(sfsw_pkg::OP_STATUS_WRITE);
    i_host.byte1(b1);
    if (nb >= 16) i_host.byte1(b2);
    if (nb == 9) i_host.cyc(2'b00, 1'b1);
    i_host.stop();
  endtask : sw
  // Watchdog
  initial begin
    repeat (90000) @(posedge sys_clk);
    err_total++;
    finish_test();
  end
  // Main sequence
  initial begin
    repeat (2) @(negedge sys_clk);
    rstn = 1'b1;
    repeat (5) @(negedge sys_clk);
    rd_test(sfsw_pkg::OP_READ, 24'hfffffe, 8'h00, 3, 1'b0);
    rd_test(sfsw_pkg::OP_FAST_READ, 24'h000120, 8'h00, 2, 1'b0);
    rd_test(sfsw_pkg::OP_DUAL_OUT, 24'h00abcd, 8'h00, 2, 1'b0);
    rd_test(sfsw_pkg::OP_DUAL_IO, 24'h123456, 8'h20, 2, 1'b0);
    chk(24'(cont_mode), 24'h1);
    rd_test(sfsw_pkg::OP_DUAL_IO, 24'h00fff0, 8'h00, 1, 1'b1);
    chk(24'(cont_mode), 24'h0);
    rd_test(sfsw_pkg::OP_READ, 24'h000010, 8'h00, 1, 1'b0);
    sw(8'hff, 8'hff, 16);
    chk(24'(status_reg), 24'h0000);
    write_enable_command();
    chk(24'(status_reg), 24'h0002);
    sw(8'hfc, 8'h00, 9);
    chk(24'(status_reg), 24'h0002);
    sw(8'hfc, 8'hc6, 16);
    chk(24'(status_reg), 24'h42ff);
    i_host.start();
    i_host.byte1(sfsw_pkg::OP_FAST_READ);
    repeat (4) i_host.byte1(8'h00);
    i_host.rd1(r);
    chk(24'(io1_oe_n), 24'h1);
    i_host.stop();
    i_host.start();
    i_host.byte1(sfsw_pkg::OP_STAT_RD_LO);
    i_host.rd1(r);
    i_host.stop();
    chk(24'(r), 24'hff);
    chk(24'(status_reg[0]), 24'h1);
    wait_idle();
    chk(24'(status_reg), 24'h42fc);
    write_enable_command();
    sw(8'h80, 8'h00, 8);
    wait_idle();
    chk(24'(status_reg), 24'h0080);
    wp_n = 1'b0;
    write_enable_command();
    sw(8'h00, 8'h00, 8);
    wait_idle();
    chk(24'(status_reg & 16'hfffc), 24'h0080);
    wp_n = 1'b1;
    write_enable_command();
    sw(8'h00, 8'h00, 8);
    wait_idle();
    chk(24'(status_reg), 24'h0000);
    finish_test();
  end
endmodule : test_serial_flash_status_write_and_reads
